// ===== bench/sio_host_model.sv
// host controller model that drives the input terminal pins
`timescale 1ns/10ps
module sio_host_model (
  input  wire logic [6:0] func_req_i,
  output logic      [6:0] term_o
);
  // per-terminal pin polarity
  // overtravel pins 3 and 4 active high, so a broken wire that reads low shows no overtravel
  assign term_o = func_req_i ^ 7'h73;
endmodule // sio_host_model

// ===== bench/sio_map_sva.sv
// assertions on the ports of the servo discrete i/o signal map
`timescale 1ns/10ps
module sio_map_sva #(
  parameter int SPD_W = 16
) (
  input wire logic                    clock_i,
  input wire logic                    rst_b_i,
  input wire logic [6:0]              term_i,
  input wire logic [3:0]              control_mode_digit_i,
  input wire logic                    drive_alarm_i,
  input wire logic                    servo_accept_i,
  input wire logic signed [SPD_W-1:0] motor_speed_i,
  input wire logic [SPD_W-1:0]        rotate_thresh_i,
  input wire logic                    drive_fault_out_o,
  input wire logic                    motor_rotating_out_o,
  input wire logic                    servo_ready_out_o,
  input wire logic                    speed_coincide_out_o,
  input wire logic                    div_pulse_a_o,
  input wire logic                    div_pulse_b_o,
  input wire logic                    servo_on_o,
  input wire logic                    fwd_overtravel_in_o,
  input wire logic                    rev_overtravel_in_o,
  input wire logic                    zero_hold_in_o,
  input wire logic                    pulse_inhibit_o,
  input wire logic signed [SPD_W-1:0] speed_ref_eff_o,
  input wire logic                    ref_pulse_o,
  input wire logic                    fwd_drive_en_o,
  input wire logic                    rev_drive_en_o,
  input wire logic [15:0]             input_alloc_param_a_o,
  input wire logic [15:0]             input_alloc_param_b_o
);
  logic [SPD_W-1:0] speed_mag;
  // the unsigned result holds even the magnitude of the most negative code, so it never wraps
  assign speed_mag = motor_speed_i[SPD_W-1] ? SPD_W'(-motor_speed_i) : SPD_W'(motor_speed_i);

  default clocking cb @(posedge clock_i);
  endclocking
  default disable iff (!rst_b_i);

  fault_flag_a:
    assert property ($past(rst_b_i) |-> drive_fault_out_o == !$past(drive_alarm_i))
    else $error("fault output wrong");
  rotating_flag_a:
    assert property ($past(rst_b_i) |->
      motor_rotating_out_o == ($past(speed_mag) > $past(rotate_thresh_i)))
    else $error("rotating output wrong");
  ready_flag_a:
    assert property ($past(rst_b_i) |->
      servo_ready_out_o == $past(servo_accept_i && !drive_alarm_i))
    else $error("ready output wrong");
  coincide_mode_a:
    assert property ((control_mode_digit_i inside {4'h1, 4'h2, 4'h8}) [*3] |->
      !speed_coincide_out_o)
    else $error("coincidence outside speed mode");
  alloc_default_a:
    assert property ((control_mode_digit_i <= 4'h2) [*3] |->
      input_alloc_param_a_o == 16'h2100 && input_alloc_param_b_o == 16'h6543)
    else $error("default allocation words wrong");
  alloc_network_a:
    assert property ((control_mode_digit_i >= 4'hC) [*3] |->
      input_alloc_param_a_o == 16'h8880 && input_alloc_param_b_o == 16'h8888)
    else $error("network allocation words wrong");
  sync_delay_a:
    assert property ((!term_i[0] && control_mode_digit_i < 4'hC) [*6] |-> servo_on_o)
    else $error("servo on late through synchroniser");
  travel_stop_a:
    assert property (!(fwd_overtravel_in_o && fwd_drive_en_o) &&
      !(rev_overtravel_in_o && rev_drive_en_o))
    else $error("drive enabled into overtravel");
  travel_pin_a:
    assert property ((term_i[3:2] == 2'b11 && control_mode_digit_i < 4'hC) [*6] |->
      !fwd_drive_en_o && !rev_drive_en_o)
    else $error("drive enabled with overtravel pins set");
  zero_clamp_a:
    assert property (zero_hold_in_o |-> speed_ref_eff_o == '0)
    else $error("reference not clamped");
  pulse_block_a:
    assert property (pulse_inhibit_o |-> !ref_pulse_o)
    else $error("reference pulse passed while inhibited");
  quad_step_a:
    assert property (!($changed(div_pulse_a_o) && $changed(div_pulse_b_o)))
    else $error("both divided phases moved at once");
endmodule // sio_map_sva

bind sio_map sio_map_sva #(.SPD_W(SPD_W)) sva_u (
  .clock_i, .rst_b_i, .term_i, .control_mode_digit_i, .drive_alarm_i, .servo_accept_i,
  .motor_speed_i, .rotate_thresh_i, .drive_fault_out_o, .motor_rotating_out_o,
  .servo_ready_out_o, .speed_coincide_out_o, .div_pulse_a_o, .div_pulse_b_o, .servo_on_o,
  .fwd_overtravel_in_o, .rev_overtravel_in_o, .zero_hold_in_o, .pulse_inhibit_o,
  .speed_ref_eff_o, .ref_pulse_o, .fwd_drive_en_o, .rev_drive_en_o,
  .input_alloc_param_a_o, .input_alloc_param_b_o
);

// ===== bench/sio_map_tb_top.sv
// self-checking bench of the servo discrete i/o signal map
`timescale 1ns/10ps
module sio_map_tb_top;
  typedef struct {int kind; logic [15:0] exp;} sio_note_t;
  logic clock_i = 1'b0, rst_b_i = 1'b0, ref_pulse_i = 1'b0;
  logic [6:0] func_req = 7'h00, term_i;
  logic [3:0] control_mode_digit_i = 4'h0, out_sel0_i = 4'h0, out_sel1_i = 4'h0, out_sel2_i = 4'h0;
  logic drive_alarm_i = 1'b0, servo_accept_i = 1'b0, torque_limiting_i = 1'b0, brake_i = 1'b0;
  logic speed_limiting_i = 1'b0, warning_i = 1'b0, pulse_select_ack_i = 1'b0;
  logic enc_a_i = 1'b0, enc_b_i = 1'b0, enc_z_i = 1'b0;
  logic signed [15:0] motor_speed_i = 16'h0000, speed_ref_i = 16'h0000, speed_ref_eff_o;
  logic [15:0] rotate_thresh_i = 16'h0000, coincide_band_i = 16'h0000, div_ratio_i = 16'h0001;
  logic signed [23:0] pos_dev_i = 24'h000000;
  logic [23:0] done_limit_i = 24'h000000, close_limit_i = 24'h000000;
  logic drive_fault_out_o, motor_rotating_out_o, servo_ready_out_o, speed_coincide_out_o;
  logic position_done_out_o, div_pulse_a_o, div_pulse_b_o, origin_pulse_c_o, servo_on_o;
  logic proportional_action_in_o, fwd_overtravel_in_o, rev_overtravel_in_o, fault_clear_in_o;
  logic fwd_torque_limit_in_o, rev_torque_limit_in_o, rotation_direction_in_o, mode_select_o;
  logic preset_speed_sel0_in_o, preset_speed_sel1_in_o, zero_hold_in_o, pulse_inhibit_o;
  logic ref_pulse_o, fwd_drive_en_o, rev_drive_en_o;
  logic [2:0] out_slot_o;
  logic [15:0] input_alloc_param_a_o, input_alloc_param_b_o, ex;
  sio_pkg::sio_ctl_t active_mode_o;
  sio_note_t notes[$];
  sio_note_t cur;
  event sample_ev;
  int error_cnt = 0, samples_checked = 0, m, sp, rf, th, bd, pd, dl, al, ac, p;
  int act_tbl [16] = '{0, 1, 2, 3, 0, 1, 2, 1, 1, 2, 0, 1, 4, 4, 4, 4};
  logic [3:0] e_mode [8] = '{4'h0, 4'h3, 4'h7, 4'hA, 4'hB, 4'hC, 4'h5, 4'h8};
  logic [12:0] e_map [8] = '{13'h1FC0, 13'h1738, 13'h17C4, 13'h17C2, 13'h17C1, 13'h0000,
                             13'h1738, 13'h17C4};
  int e_act [8] = '{0, 3, 0, 0, 1, 4, 3, 2};

  sio_host_model host_u (.func_req_i(func_req), .term_o(term_i));
  sio_map dut_u (
    .clock_i, .rst_b_i, .term_i, .control_mode_digit_i, .drive_alarm_i, .servo_accept_i,
    .motor_speed_i, .speed_ref_i, .rotate_thresh_i, .coincide_band_i, .pos_dev_i,
    .done_limit_i, .close_limit_i, .torque_limiting_i, .speed_limiting_i, .brake_i,
    .warning_i, .pulse_select_ack_i, .out_sel0_i, .out_sel1_i, .out_sel2_i, .enc_a_i,
    .enc_b_i, .enc_z_i, .div_ratio_i, .ref_pulse_i, .drive_fault_out_o, .motor_rotating_out_o,
    .servo_ready_out_o, .speed_coincide_out_o, .position_done_out_o, .out_slot_o,
    .div_pulse_a_o, .div_pulse_b_o, .origin_pulse_c_o, .servo_on_o, .proportional_action_in_o,
    .fwd_overtravel_in_o, .rev_overtravel_in_o, .fault_clear_in_o, .fwd_torque_limit_in_o,
    .rev_torque_limit_in_o, .rotation_direction_in_o, .preset_speed_sel0_in_o,
    .preset_speed_sel1_in_o, .mode_select_o, .zero_hold_in_o, .pulse_inhibit_o, .active_mode_o,
    .speed_ref_eff_o, .ref_pulse_o, .fwd_drive_en_o, .rev_drive_en_o, .input_alloc_param_a_o,
    .input_alloc_param_b_o
  );

  initial forever #2.5 clock_i = ~clock_i;

  function automatic int mag(int v);
    return v < 0 ? -v : v;
  endfunction
  // slot pattern set up below: even function codes true, codes above 8 hold the slot low
  function automatic logic fn(int c);
    return c > 8 ? 1'b0 : !c[0];
  endfunction
  function automatic logic [15:0] obs(int k);
    case (k)
      0: obs = {11'h000, drive_fault_out_o, motor_rotating_out_o, servo_ready_out_o,
                speed_coincide_out_o, position_done_out_o};
      1: obs = input_alloc_param_a_o;
      2: obs = input_alloc_param_b_o;
      3: obs = {3'h0, servo_on_o, proportional_action_in_o, fwd_overtravel_in_o,
                rev_overtravel_in_o, fault_clear_in_o, fwd_torque_limit_in_o,
                rev_torque_limit_in_o, rotation_direction_in_o, preset_speed_sel0_in_o,
                preset_speed_sel1_in_o, mode_select_o, zero_hold_in_o, pulse_inhibit_o};
      4: obs = {13'h0000, out_slot_o};
      5: obs = {14'h0000, fwd_drive_en_o, rev_drive_en_o};
      6: obs = speed_ref_eff_o;
      7: obs = {13'h0000, active_mode_o};
      8: obs = {15'h0000, ref_pulse_o};
      default: obs = {13'h0000, div_pulse_a_o, div_pulse_b_o, origin_pulse_c_o};
    endcase
  endfunction

  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    samples_checked++;
    if (seen !== exp)
    begin
      error_cnt++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  // the monitor compares on the falling edge, where registered outputs have settled
  task automatic note(input int k, input logic [15:0] e, input int lat);
    notes.push_back('{k, e});
    repeat (lat) @(posedge clock_i);
    @(negedge clock_i);
    -> sample_ev;
  endtask
  task automatic end_of_test();
    if (notes.size() != 0)
      error_cnt++;
    $display("checks %0d errors %0d", samples_checked, error_cnt);
    if (error_cnt == 0 && samples_checked > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask

  initial
  forever
  begin
    @(sample_ev);
    cur = notes.pop_front();
    check(obs(cur.kind), cur.exp);
  end

  initial
  begin
    repeat (20000) @(posedge clock_i);
    error_cnt++;
    end_of_test();
  end

  initial
  begin
    void'($urandom(32'h35CB3E26));
    repeat (10) @(posedge clock_i);
    rst_b_i <= 1'b1;
    repeat (4) @(posedge clock_i);
    for (int i = 0; i < 24; i++)
    begin
      m = $urandom_range(2);
      sp = int'($urandom_range(4000)) - 2000;
      rf = sp + int'($urandom_range(600)) - 300;
      th = $urandom_range(2000);
      bd = $urandom_range(300);
      pd = int'($urandom_range(2000)) - 1000;
      dl = $urandom_range(1000);
      al = $urandom_range(1);
      ac = $urandom_range(1);
      @(posedge clock_i);
      control_mode_digit_i <= 4'(m);
      motor_speed_i <= 16'(sp);
      speed_ref_i <= 16'(rf);
      rotate_thresh_i <= 16'(th);
      coincide_band_i <= 16'(bd);
      pos_dev_i <= 24'(pd);
      done_limit_i <= 24'(dl);
      close_limit_i <= 24'(dl);
      drive_alarm_i <= al[0];
      servo_accept_i <= ac[0];
      ex = {11'h000, al == 0, mag(sp) > th, ac == 1 && al == 0,
            m == 0 && mag(sp - rf) <= bd, m == 1 && mag(pd) <= dl};
      note(0, ex, 1);
    end
    for (int k = 0; k < 16; k++)
    begin
      @(posedge clock_i);
      control_mode_digit_i <= 4'(k);
      note(1, k < 3 ? 16'h2100 : k < 12 ? 16'h2800 : 16'h8880, 1);
      note(2, k < 3 ? 16'h6543 : k < 7 ? 16'h8843 : k < 12 ? 16'h6543 : 16'h8888, 0);
      note(7, 16'(act_tbl[k]), 0);
    end
    @(posedge clock_i);
    func_req <= 7'h7F;
    speed_ref_i <= 16'h0123;
    ref_pulse_i <= 1'b1;
    for (int k = 0; k < 8; k++)
    begin
      @(posedge clock_i);
      control_mode_digit_i <= e_mode[k];
      note(3, {3'h0, e_map[k]}, 8);
      note(5, {14'h0000, !e_map[k][10], !e_map[k][9]}, 0);
      note(6, k == 3 ? 16'h0000 : 16'h0123, 0);
      note(7, 16'(e_act[k]), 0);
      note(8, 16'(k != 4), 0);
    end
    @(posedge clock_i);
    func_req <= 7'h00;
    ref_pulse_i <= 1'b0;
    control_mode_digit_i <= 4'h0;
    {drive_alarm_i, servo_accept_i, torque_limiting_i, brake_i} <= 4'h0;
    {speed_limiting_i, warning_i, pulse_select_ack_i} <= 3'h7;
    motor_speed_i <= 16'h01F4;
    speed_ref_i <= 16'h01F4;
    rotate_thresh_i <= 16'h0064;
    coincide_band_i <= 16'h0000;
    div_ratio_i <= 16'h0002;
    for (int c = 0; c < 10; c++)
    begin
      @(posedge clock_i);
      out_sel0_i <= 4'(c);
      out_sel1_i <= 4'((c + 1) % 9);
      out_sel2_i <= 4'(15 - c);
      note(4, {13'h0000, fn(15 - c), fn((c + 1) % 9), fn(c)}, 2);
    end
    for (int s = 1; s < 9; s++)
    begin
      @(posedge clock_i);
      enc_b_i <= s[1];
      enc_a_i <= s[1] ^ s[0];
      p = s / 2;
      note(9, {13'h0000, p[1] ^ p[0], p[1], 1'b0}, 8);
    end
    @(posedge clock_i);
    enc_z_i <= 1'b1;
    note(9, 16'h0001, 8);
    @(posedge clock_i);
    enc_z_i <= 1'b0;
    note(9, 16'h0000, 8);
    @(posedge clock_i);
    end_of_test();
  end
endmodule // sio_map_tb_top

// ===== design/sio_defines.svh
// constants of the servo discrete i/o signal map
`ifndef SIO_DEFINES_SVH
`define SIO_DEFINES_SVH

// terminal slots, index 0 is terminal 1
`define SIO_N_TERM      7
`define SIO_T1          0
`define SIO_T2          1
`define SIO_T3          2
`define SIO_T4          3
`define SIO_T5          4
`define SIO_T6          5
`define SIO_T7          6
// terminals whose function is active high at the pin (overtravels)
`define SIO_ACT_HIGH    7'h0C
// synchroniser reset levels: idle pins, active-low terminals high, overtravels and encoder low
`define SIO_SYNC_RST    10'h073

// mode digit values
`define SIO_MD_SPEED    4'h0
`define SIO_MD_POS      4'h1
`define SIO_MD_TRQ      4'h2
`define SIO_MD_PRE      4'h3
`define SIO_MD_PRE_SPD  4'h4
`define SIO_MD_PRE_POS  4'h5
`define SIO_MD_PRE_TRQ  4'h6
`define SIO_MD_POS_SPD  4'h7
`define SIO_MD_POS_TRQ  4'h8
`define SIO_MD_TRQ_SPD  4'h9
`define SIO_MD_ZERO_HOLD_IN   4'hA
`define SIO_MD_INHIBIT  4'hB
`define SIO_MD_NETWORK  4'hC

// allocation digit codes: terminal code 0..6, never active 8
`define SIO_ALLOC_NONE  4'h8
`define SIO_ALLOC_T1    4'h0
`define SIO_ALLOC_T2    4'h1
`define SIO_ALLOC_T3    4'h2
`define SIO_ALLOC_T4    4'h3
`define SIO_ALLOC_T5    4'h4
`define SIO_ALLOC_T6    4'h5
`define SIO_ALLOC_T7    4'h6
`define SIO_ALLOC_MODE  4'h0

// output slot count and number of output functions
`define SIO_N_SLOT      3
`define SIO_N_FUNC      9

`endif

// ===== design/sio_map.sv
// servo discrete i/o: input terminal mapping, status flags, divided encoder output
`timescale 1ns/10ps
`include "sio_defines.svh"

module sio_map #(
  parameter int SPD_W = 16,
  parameter int POS_W = 24,
  parameter int DIV_W = 16
) (
  input  wire logic                clock_i,
  input  wire logic                rst_b_i,
  input  wire logic [6:0]          term_i,
  input  wire logic [3:0]          control_mode_digit_i,
  input  wire logic                drive_alarm_i,
  input  wire logic                servo_accept_i,
  input  wire logic signed [SPD_W-1:0] motor_speed_i,
  input  wire logic signed [SPD_W-1:0] speed_ref_i,
  input  wire logic [SPD_W-1:0]    rotate_thresh_i,
  input  wire logic [SPD_W-1:0]    coincide_band_i,
  input  wire logic signed [POS_W-1:0] pos_dev_i,
  input  wire logic [POS_W-1:0]    done_limit_i,
  input  wire logic [POS_W-1:0]    close_limit_i,
  input  wire logic                torque_limiting_i,
  input  wire logic                speed_limiting_i,
  input  wire logic                brake_i,
  input  wire logic                warning_i,
  input  wire logic                pulse_select_ack_i,
  input  wire logic [3:0]          out_sel0_i,
  input  wire logic [3:0]          out_sel1_i,
  input  wire logic [3:0]          out_sel2_i,
  input  wire logic                enc_a_i,
  input  wire logic                enc_b_i,
  input  wire logic                enc_z_i,
  input  wire logic [DIV_W-1:0]    div_ratio_i,
  input  wire logic                ref_pulse_i,
  output logic                     drive_fault_out_o,
  output logic                     motor_rotating_out_o,
  output logic                     servo_ready_out_o,
  output logic                     speed_coincide_out_o,
  output logic                     position_done_out_o,
  output logic [2:0]               out_slot_o,
  output logic                     div_pulse_a_o,
  output logic                     div_pulse_b_o,
  output logic                     origin_pulse_c_o,
  output logic                     servo_on_o,
  output logic                     proportional_action_in_o,
  output logic                     fwd_overtravel_in_o,
  output logic                     rev_overtravel_in_o,
  output logic                     fault_clear_in_o,
  output logic                     fwd_torque_limit_in_o,
  output logic                     rev_torque_limit_in_o,
  output logic                     rotation_direction_in_o,
  output logic                     preset_speed_sel0_in_o,
  output logic                     preset_speed_sel1_in_o,
  output logic                     mode_select_o,
  output logic                     zero_hold_in_o,
  output logic                     pulse_inhibit_o,
  output sio_pkg::sio_ctl_t        active_mode_o,
  output logic signed [SPD_W-1:0]  speed_ref_eff_o,
  output logic                     ref_pulse_o,
  output logic                     fwd_drive_en_o,
  output logic                     rev_drive_en_o,
  output logic [15:0]              input_alloc_param_a_o,
  output logic [15:0]              input_alloc_param_b_o
);

  localparam int NS = `SIO_N_TERM + 3;
  // reset to idle levels so no function looks active while the stages fill
  localparam logic [NS-1:0] SYNC_RST = `SIO_SYNC_RST;

  logic [NS-1:0] raw;
  logic [NS-1:0] s1_ff;
  logic [NS-1:0] s2_ff;
  logic [NS-1:0] s3_ff;
  logic [NS-1:0] filt_ff;
  assign raw = {enc_z_i, enc_b_i, enc_a_i, term_i};

  genvar gi;
  generate
    for (gi = 0; gi < NS; gi++)
    begin : g_sync
      always_ff @(posedge clock_i)
      begin
        if (!rst_b_i)
        begin
          s1_ff[gi]   <= SYNC_RST[gi];
          s2_ff[gi]   <= SYNC_RST[gi];
          s3_ff[gi]   <= SYNC_RST[gi];
          filt_ff[gi] <= SYNC_RST[gi];
        end
        else
        begin
          s1_ff[gi] <= raw[gi];
          s2_ff[gi] <= s1_ff[gi];
          s3_ff[gi] <= s2_ff[gi];
          if (s2_ff[gi] == s3_ff[gi])
            filt_ff[gi] <= s3_ff[gi];
        end
      end
    end
  endgenerate

  // terminal level to function-active level
  wire [6:0] act = ~(filt_ff[6:0] ^ `SIO_ACT_HIGH);
  wire [3:0] md  = control_mode_digit_i;

  wire m_basic  = (md <= `SIO_MD_TRQ);
  wire m_preset = (md >= `SIO_MD_PRE) && (md <= `SIO_MD_PRE_TRQ);
  wire m_switch = (md >= `SIO_MD_POS_SPD) && (md <= `SIO_MD_TRQ_SPD);
  wire m_zero_hold_in = (md == `SIO_MD_ZERO_HOLD_IN);
  // inhibit mode puts the inhibit on terminal 2; network and unused codes carry no terminal
  wire m_inhib  = (md == `SIO_MD_INHIBIT);
  wire m_term   = (md < `SIO_MD_NETWORK);

  wire f_son  = m_term & act[`SIO_T1];
  wire f_pot  = m_term & act[`SIO_T3];
  wire f_not  = m_term & act[`SIO_T4];
  wire f_clr  = m_term & act[`SIO_T5];
  wire f_pcl  = m_term & ~m_preset & act[`SIO_T6];
  wire f_ncl  = m_term & ~m_preset & act[`SIO_T7];
  wire f_pcon = m_basic & act[`SIO_T2];
  wire f_dir  = m_preset & act[`SIO_T2];
  wire f_spda = m_preset & act[`SIO_T6];
  wire f_spdb = m_preset & act[`SIO_T7];
  wire f_csel = m_switch & act[`SIO_T2];
  wire f_zhld = m_zero_hold_in & act[`SIO_T2];
  wire f_inh  = m_inhib & act[`SIO_T2];

  // control mode from digit and select level
  sio_pkg::sio_ctl_t nxt_mode;
  wire pre_on = f_spda | f_spdb;
  always_comb
  begin
    case (md)
      `SIO_MD_SPEED:   nxt_mode = sio_pkg::SIO_CTL_SPEED;
      `SIO_MD_POS:     nxt_mode = sio_pkg::SIO_CTL_POSITION;
      `SIO_MD_TRQ:     nxt_mode = sio_pkg::SIO_CTL_TORQUE;
      `SIO_MD_PRE:     nxt_mode = sio_pkg::SIO_CTL_PRESET;
      `SIO_MD_PRE_SPD: nxt_mode = pre_on ? sio_pkg::SIO_CTL_PRESET : sio_pkg::SIO_CTL_SPEED;
      `SIO_MD_PRE_POS: nxt_mode = pre_on ? sio_pkg::SIO_CTL_PRESET : sio_pkg::SIO_CTL_POSITION;
      `SIO_MD_PRE_TRQ: nxt_mode = pre_on ? sio_pkg::SIO_CTL_PRESET : sio_pkg::SIO_CTL_TORQUE;
      `SIO_MD_POS_SPD: nxt_mode = f_csel ? sio_pkg::SIO_CTL_SPEED : sio_pkg::SIO_CTL_POSITION;
      `SIO_MD_POS_TRQ: nxt_mode = f_csel ? sio_pkg::SIO_CTL_TORQUE : sio_pkg::SIO_CTL_POSITION;
      `SIO_MD_TRQ_SPD: nxt_mode = f_csel ? sio_pkg::SIO_CTL_SPEED : sio_pkg::SIO_CTL_TORQUE;
      `SIO_MD_ZERO_HOLD_IN:  nxt_mode = sio_pkg::SIO_CTL_SPEED;
      `SIO_MD_INHIBIT: nxt_mode = sio_pkg::SIO_CTL_POSITION;
      default:         nxt_mode = sio_pkg::SIO_CTL_NETWORK;
    endcase
  end

  // allocation words, code 8 marks an unused function
  wire [3:0] a_son  = m_term ? `SIO_ALLOC_T1 : `SIO_ALLOC_NONE;
  wire [3:0] a_pcon = m_basic ? `SIO_ALLOC_T2 : `SIO_ALLOC_NONE;
  wire [3:0] a_pot  = m_term ? `SIO_ALLOC_T3 : `SIO_ALLOC_NONE;
  wire [3:0] a_not  = m_term ? `SIO_ALLOC_T4 : `SIO_ALLOC_NONE;
  wire [3:0] a_clr  = m_term ? `SIO_ALLOC_T5 : `SIO_ALLOC_NONE;
  wire [3:0] a_pcl  = (m_term & ~m_preset) ? `SIO_ALLOC_T6 : `SIO_ALLOC_NONE;
  wire [3:0] a_ncl  = (m_term & ~m_preset) ? `SIO_ALLOC_T7 : `SIO_ALLOC_NONE;
  wire [15:0] nxt_alloc_a = {a_pot, a_pcon, a_son, `SIO_ALLOC_MODE};
  wire [15:0] nxt_alloc_b = {a_ncl, a_pcl, a_clr, a_not};

  // magnitudes, one bit wider so the most negative value is safe
  wire signed [SPD_W:0] spd_x  = (SPD_W+1)'(motor_speed_i);
  wire [SPD_W:0]        spd_m  = spd_x[SPD_W] ? (SPD_W+1)'(-spd_x) : spd_x;
  wire signed [SPD_W-1:0] ref_eff;
  assign ref_eff = f_zhld ? SPD_W'(0) : speed_ref_i;
  wire signed [SPD_W:0] err_x  = (SPD_W+1)'(motor_speed_i) - (SPD_W+1)'(ref_eff);
  wire [SPD_W:0]        err_m  = err_x[SPD_W] ? (SPD_W+1)'(-err_x) : err_x;
  wire signed [POS_W:0] dev_x  = (POS_W+1)'(pos_dev_i);
  wire [POS_W:0]        dev_m  = dev_x[POS_W] ? (POS_W+1)'(-dev_x) : dev_x;

  wire fl_rot   = spd_m > {1'b0, rotate_thresh_i};
  // ready only when servo-on is acceptable
  wire fl_rdy   = servo_accept_i & ~drive_alarm_i;
  wire fl_vcmp  = (nxt_mode == sio_pkg::SIO_CTL_SPEED) & (err_m <= {1'b0, coincide_band_i});
  wire fl_position_done_out  = (nxt_mode == sio_pkg::SIO_CTL_POSITION) & (dev_m <= {1'b0, done_limit_i});
  wire fl_close = (nxt_mode == sio_pkg::SIO_CTL_POSITION) & (dev_m <= {1'b0, close_limit_i});
  // shared pin: coincidence or done, whichever mode is active
  wire fl_cmp   = fl_vcmp | fl_position_done_out;

  wire [`SIO_N_FUNC-1:0] flags = {pulse_select_ack_i, fl_close, warning_i, brake_i,
                                  speed_limiting_i, torque_limiting_i, fl_cmp, fl_rdy, fl_rot};
  wire [3:0] sel [`SIO_N_SLOT];
  assign sel[0] = out_sel0_i;
  assign sel[1] = out_sel1_i;
  assign sel[2] = out_sel2_i;
  logic [`SIO_N_SLOT-1:0] slot_ff;

  generate
    for (gi = 0; gi < `SIO_N_SLOT; gi++)
    begin : g_slot
      wire nxt_slot = (sel[gi] < 4'(`SIO_N_FUNC)) ? flags[sel[gi]] : 1'b0;
      always_ff @(posedge clock_i)
      begin
        if (!rst_b_i)
          slot_ff[gi] <= 1'b0;
        else
          slot_ff[gi] <= nxt_slot;
      end
    end
  endgenerate
  assign out_slot_o = slot_ff;

  // quadrature decode of encoder, divide, re-encode
  logic [1:0] ab_ff;
  logic signed [DIV_W:0] acc_ff;
  logic [1:0] ph_ff;
  wire [1:0] ab = filt_ff[8:7];
  wire step = ab != ab_ff;
  // gray sequence 00,01,11,10 is forward
  wire fwd  = ~(ab_ff[0] ^ ab[1]);
  wire signed [DIV_W:0] acc_s = fwd ? acc_ff + (DIV_W+1)'(1) : acc_ff - (DIV_W+1)'(1);
  wire signed [DIV_W:0] lim   = (DIV_W+1)'(div_ratio_i);
  wire ovf = step & (acc_s >= lim);
  wire unf = step & (acc_s <= -lim);
  wire signed [DIV_W:0] nxt_acc = (ovf | unf) ? (DIV_W+1)'(0) : (step ? acc_s : acc_ff);
  // zero ratio gives a copy rather than a stuck output
  wire [1:0] nxt_ph = ovf ? ph_ff + 2'h1 : (unf ? ph_ff - 2'h1 : ph_ff);

  always_ff @(posedge clock_i)
  begin
    if (!rst_b_i)
    begin
      ab_ff  <= 2'h0;
      acc_ff <= '0;
      ph_ff  <= 2'h0;
    end
    else
    begin
      ab_ff  <= ab;
      acc_ff <= nxt_acc;
      ph_ff  <= nxt_ph;
    end
  end

  // b lags a by a quarter period
  logic pa_ff;
  logic pb_ff;
  logic pc_ff;
  always_ff @(posedge clock_i)
  begin
    if (!rst_b_i)
    begin
      pa_ff <= 1'b0;
      pb_ff <= 1'b0;
      pc_ff <= 1'b0;
    end
    else
    begin
      pa_ff <= ph_ff[1] ^ ph_ff[0];
      pb_ff <= ph_ff[1];
      pc_ff <= filt_ff[9];
    end
  end
  assign div_pulse_a_o    = pa_ff;
  assign div_pulse_b_o    = pb_ff;
  assign origin_pulse_c_o = pc_ff;

  // registered status and mapped inputs
  logic [12:0] fn_ff;
  logic [4:0]  st_ff;
  sio_pkg::sio_ctl_t mode_ff;
  logic signed [SPD_W-1:0] ref_ff;
  logic [15:0] alloc_a_ff;
  logic [15:0] alloc_b_ff;
  logic ref_pulse_ff;

  wire nxt_fault = ~drive_alarm_i;
  wire nxt_fwd_en = ~f_pot;
  wire nxt_rev_en = ~f_not;
  wire nxt_ref_pulse = ref_pulse_i & ~f_inh;

  always_ff @(posedge clock_i)
  begin
    if (!rst_b_i)
    begin
      fn_ff        <= '0;
      st_ff        <= '0;
      mode_ff      <= sio_pkg::SIO_CTL_NETWORK;
      ref_ff       <= '0;
      alloc_a_ff   <= 16'h0000;
      alloc_b_ff   <= 16'h0000;
      ref_pulse_ff <= 1'b0;
    end
    else
    begin
      fn_ff        <= {f_inh, f_zhld, f_csel, f_spdb, f_spda, f_dir, f_ncl, f_pcl,
                       f_clr, f_not, f_pot, f_pcon, f_son};
      st_ff        <= {fl_position_done_out, fl_vcmp, fl_rdy, fl_rot, nxt_fault};
      mode_ff      <= nxt_mode;
      ref_ff       <= ref_eff;
      alloc_a_ff   <= nxt_alloc_a;
      alloc_b_ff   <= nxt_alloc_b;
      ref_pulse_ff <= nxt_ref_pulse;
    end
  end

  logic fwd_en_ff;
  logic rev_en_ff;
  always_ff @(posedge clock_i)
  begin
    if (!rst_b_i)
    begin
      fwd_en_ff <= 1'b0;
      rev_en_ff <= 1'b0;
    end
    else
    begin
      fwd_en_ff <= nxt_fwd_en;
      rev_en_ff <= nxt_rev_en;
    end
  end

  assign servo_on_o               = fn_ff[0];
  assign proportional_action_in_o = fn_ff[1];
  assign fwd_overtravel_in_o      = fn_ff[2];
  assign rev_overtravel_in_o      = fn_ff[3];
  assign fault_clear_in_o         = fn_ff[4];
  assign fwd_torque_limit_in_o    = fn_ff[5];
  assign rev_torque_limit_in_o    = fn_ff[6];
  assign rotation_direction_in_o  = fn_ff[7];
  assign preset_speed_sel0_in_o   = fn_ff[8];
  assign preset_speed_sel1_in_o   = fn_ff[9];
  assign mode_select_o            = fn_ff[10];
  assign zero_hold_in_o           = fn_ff[11];
  assign pulse_inhibit_o          = fn_ff[12];
  assign drive_fault_out_o        = st_ff[0];
  assign motor_rotating_out_o     = st_ff[1];
  assign servo_ready_out_o        = st_ff[2];
  assign speed_coincide_out_o     = st_ff[3];
  assign position_done_out_o      = st_ff[4];
  assign active_mode_o            = mode_ff;
  assign speed_ref_eff_o          = ref_ff;
  assign ref_pulse_o              = ref_pulse_ff;
  assign fwd_drive_en_o           = fwd_en_ff;
  assign rev_drive_en_o           = rev_en_ff;
  assign input_alloc_param_a_o    = alloc_a_ff;
  assign input_alloc_param_b_o    = alloc_b_ff;

endmodule // sio_map

// ===== design/sio_pkg.sv
// types of the servo discrete i/o signal map
package sio_pkg;

  typedef enum logic [2:0] {
    SIO_CTL_SPEED,
    SIO_CTL_POSITION,
    SIO_CTL_TORQUE,
    SIO_CTL_PRESET,
    SIO_CTL_NETWORK
  } sio_ctl_t;

  // output function codes, selectable per output slot
  typedef enum logic [3:0] {
    SIO_OF_ROTATING,
    SIO_OF_READY,
    SIO_OF_COINCIDE,
    SIO_OF_TRQ_LIMIT,
    SIO_OF_SPD_LIMIT,
    SIO_OF_BRAKE,
    SIO_OF_WARNING,
    SIO_OF_CLOSE,
    SIO_OF_PSEL_ACK
  } sio_ofunc_t;

endpackage
